// ---- hw/bsmw_defs.svh ----
`ifndef BSMW_DEFS_SVH
`define BSMW_DEFS_SVH
// dword offsets (byte addresses)
`define BSMW_OFF_SECSTAT 8'h1C
`define BSMW_OFF_MEMWIN 8'h20
`define BSMW_OFF_PFWIN 8'h24
`define BSMW_OFF_PFBASEHI 8'h28
`define BSMW_OFF_PFLIMHI 8'h2C
`define BSMW_OFF_CMD 8'h04
// secondary status bits within the 0x1C dword
`define BSMW_BIT_66MHZ 21
`define BSMW_BIT_FB2B 23
`define BSMW_BIT_MDPERR 24
`define BSMW_DEVSEL_LO 25
`define BSMW_DEVSEL_HI 26
`define BSMW_DEVSEL_MEDIUM 2'h1
`define BSMW_BIT_STABORT 27
`define BSMW_BIT_RTABORT 28
`define BSMW_BIT_RMABORT 29
`define BSMW_BIT_RSERR 30
`define BSMW_BIT_DPERR 31
// command register bit
`define BSMW_BIT_PERRRSP 6
// window fields
`define BSMW_BASE_LO 4
`define BSMW_BASE_HI 15
`define BSMW_LIM_LO 20
`define BSMW_LIM_HI 31
`define BSMW_PF64_NIB 4'h1
`define BSMW_LOW20_ZERO 20'h00000
`define BSMW_LOW20_ONES 20'hFFFFF
`endif

// ---- hw/bsmw_pkg.sv ----
package bsmw_pkg;
  typedef logic [11:0] bsmw_field_t;
  typedef logic [63:0] bsmw_addr_t;
endpackage

// ---- hw/bsmw_regs.sv ----
// Overview of operation
// [RULE_01] status bit 21 reads one, 66MHz
// [RULE_02] status bit 23 reads zero, fast b2b
// [RULE_03] bit 24 sets on parity error, response enabled
// [RULE_04] bits 26:25 read 01, medium decode
// [RULE_05] bit 27 sets on signalled target abort
// [RULE_06] bit 28 sets on received target abort
// [RULE_07] bit 29 sets on received master abort
// [RULE_08] bit 30 sets on secondary system error
// [RULE_09] bit 31 sets on detected parity error
// [RULE_10] memory base/limit low nibbles read zero
// [RULE_11] memory base gives window bottom bits 31:20
// [RULE_12] memory limit gives top, low bits ones
// [RULE_13] memory window decides forwarding
// [RULE_14] prefetch low nibbles read 0001, 64-bit
// [RULE_15] prefetch base gives bottom bits 31:20
// [RULE_16] prefetch limit gives top, low bits ones
// [RULE_17] prefetch window decides forwarding
// [RULE_18] upper halves extend prefetch decode to 64
// [RULE_19] inside means base <= addr <= limit
// [RULE_20] write zero keeps flags, reserved read zero
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "bsmw_defs.svh"
module bsmw_regs (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic secondary_parity_error_n,
  input wire logic secondary_system_error_n,
  input wire logic targetAbortSignaled,
  input wire logic targetAbortReceived,
  input wire logic masterAbortReceived,
  input wire logic parityErrorDetected,
  input wire logic [63:0] txnAddr,
  input wire logic txnIs64,
  output logic memWindowHit,
  output logic prefetchWindowHit,
  output logic forwardHit
);
  logic [1:0] perrSync_q;
  logic [1:0] serrSync_q;
  logic [7:0] cmd_q;
  logic [4:0] flags_q;
  logic mdperr_q;
  bsmw_pkg::bsmw_field_t memBase_q, memLimit_q, pfBase_q, pfLimit_q;
  logic [31:0] pfBaseHi_q, pfLimitHi_q;
  logic wrStat, wrMem, wrPf, wrCmd;
  bsmw_pkg::bsmw_addr_t memLo, memHi, pfLo, pfHi, addrEff;
  logic [31:0] statWord, memWord, pfWord;

  // pins are asynchronous to the register clock
  always_ff @(posedge clock) begin
    if (rst) begin
      perrSync_q <= 2'h3;
      serrSync_q <= 2'h3;
    end else begin
      perrSync_q <= {perrSync_q[0], secondary_parity_error_n};
      serrSync_q <= {serrSync_q[0], secondary_system_error_n};
    end
  end

  assign wrStat = regWrite && (regAddr == `BSMW_OFF_SECSTAT);
  assign wrMem = regWrite && (regAddr == `BSMW_OFF_MEMWIN);
  assign wrPf = regWrite && (regAddr == `BSMW_OFF_PFWIN);
  assign wrCmd = regWrite && (regAddr == `BSMW_OFF_CMD);

  // command low byte, holds parity error response
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_q <= 8'h00;
    end else if (wrCmd) begin
      cmd_q <= regWdata[7:0];
    end
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge clock) begin
    if (rst) begin
      mdperr_q <= 1'b0;
    end else begin
      mdperr_q <= (mdperr_q && !(wrStat && regWdata[`BSMW_BIT_MDPERR]))
        || (!perrSync_q[1] && cmd_q[`BSMW_BIT_PERRRSP]); // [RULE_03] [RULE_20]
    end
  end

  // flags_q order: 27 .. 31
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_q <= 5'h00;
    end else begin
      flags_q <= (flags_q & ~(wrStat ? regWdata[`BSMW_BIT_DPERR:`BSMW_BIT_STABORT] : 5'h00)) // [RULE_20]
        | {parityErrorDetected, // [RULE_09]
           !serrSync_q[1], // [RULE_08]
           masterAbortReceived, // [RULE_07]
           targetAbortReceived, // [RULE_06]
           targetAbortSignaled}; // [RULE_05]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      memBase_q <= 12'h000;
      memLimit_q <= 12'h000;
    end else if (wrMem) begin
      memBase_q <= regWdata[`BSMW_BASE_HI:`BSMW_BASE_LO]; // [RULE_11]
      memLimit_q <= regWdata[`BSMW_LIM_HI:`BSMW_LIM_LO]; // [RULE_12]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pfBase_q <= 12'h000;
      pfLimit_q <= 12'h000;
    end else if (wrPf) begin
      pfBase_q <= regWdata[`BSMW_BASE_HI:`BSMW_BASE_LO]; // [RULE_15]
      pfLimit_q <= regWdata[`BSMW_LIM_HI:`BSMW_LIM_LO]; // [RULE_16]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pfBaseHi_q <= 32'h00000000;
      pfLimitHi_q <= 32'h00000000;
    end else begin
      if (regWrite && (regAddr == `BSMW_OFF_PFBASEHI)) begin
        pfBaseHi_q <= regWdata; // [RULE_18]
      end
      if (regWrite && (regAddr == `BSMW_OFF_PFLIMHI)) begin
        pfLimitHi_q <= regWdata; // [RULE_18]
      end
    end
  end

  // inclusive compare at both ends
  function automatic logic inWindow(input bsmw_pkg::bsmw_addr_t a, input bsmw_pkg::bsmw_addr_t lo,
                                    input bsmw_pkg::bsmw_addr_t hi);
    inWindow = (a >= lo) && (a <= hi); // [RULE_19]
  endfunction

  // memory window is 32-bit only, so upper bits must be zero
  assign memLo = {32'h00000000, memBase_q, `BSMW_LOW20_ZERO}; // [RULE_11]
  assign memHi = {32'h00000000, memLimit_q, `BSMW_LOW20_ONES}; // [RULE_12]
  assign pfLo = {pfBaseHi_q, pfBase_q, `BSMW_LOW20_ZERO}; // [RULE_15] [RULE_18]
  assign pfHi = {pfLimitHi_q, pfLimit_q, `BSMW_LOW20_ONES}; // [RULE_16] [RULE_18]
  assign addrEff = txnIs64 ? txnAddr : {32'h00000000, txnAddr[31:0]};

  // base above limit yields an empty window, which disables it
  assign memWindowHit = inWindow(addrEff, memLo, memHi); // [RULE_13]
  assign prefetchWindowHit = inWindow(addrEff, pfLo, pfHi); // [RULE_17]
  assign forwardHit = memWindowHit || prefetchWindowHit; // [RULE_13] [RULE_17]

  always_comb begin
    statWord = 32'h00000000; // [RULE_20]
    statWord[`BSMW_BIT_66MHZ] = 1'b1; // [RULE_01]
    statWord[`BSMW_BIT_FB2B] = 1'b0; // [RULE_02]
    statWord[`BSMW_BIT_MDPERR] = mdperr_q;
    statWord[`BSMW_DEVSEL_HI:`BSMW_DEVSEL_LO] = `BSMW_DEVSEL_MEDIUM; // [RULE_04]
    statWord[`BSMW_BIT_DPERR:`BSMW_BIT_STABORT] = flags_q;
  end

  assign memWord = {memLimit_q, 4'h0, memBase_q, 4'h0}; // [RULE_10]
  assign pfWord = {pfLimit_q, `BSMW_PF64_NIB, pfBase_q, `BSMW_PF64_NIB}; // [RULE_14]

  // unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      case (regAddr)
        `BSMW_OFF_CMD: regRdata <= {24'h000000, cmd_q};
        `BSMW_OFF_SECSTAT: regRdata <= statWord;
        `BSMW_OFF_MEMWIN: regRdata <= memWord;
        `BSMW_OFF_PFWIN: regRdata <= pfWord;
        `BSMW_OFF_PFBASEHI: regRdata <= pfBaseHi_q;
        `BSMW_OFF_PFLIMHI: regRdata <= pfLimitHi_q;
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end
endmodule // bsmw_regs
`default_nettype wire

// ---- sim/bsmw_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsmw_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic secondary_system_error_n,
  input wire logic targetAbortSignaled,
  input wire logic targetAbortReceived,
  input wire logic masterAbortReceived,
  input wire logic parityErrorDetected
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic rdS = regRead && regAddr == 8'h1C;
  property p_cap; rdS |=> regRdata[23:16] == 8'h20; endproperty
  a_cap: assert property (p_cap) else $error("capability bits wrong");
  property p_spd; rdS |=> regRdata[26:25] == 2'h1; endproperty
  a_spd: assert property (p_spd) else $error("decode speed wrong");
  // read data stands one cycle only, then returns to zero
  property p_idle; !regRead |=> regRdata == 32'h00000000; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_nib; regRead && regAddr == 8'h20 |=> regRdata[19:16] == 4'h0 && regRdata[3:0] == 4'h0; endproperty
  a_nib: assert property (p_nib) else $error("window nibble wrong");
  property p_pfn; regRead && regAddr == 8'h24 |=> regRdata[19:16] == 4'h1 && regRdata[3:0] == 4'h1; endproperty
  a_pfn: assert property (p_pfn) else $error("prefetch nibble wrong");
  property p_tas; targetAbortSignaled ##1 rdS |=> regRdata[27]; endproperty
  a_tas: assert property (p_tas) else $error("flag 27 missing");
  property p_tar; targetAbortReceived ##1 rdS |=> regRdata[28]; endproperty
  a_tar: assert property (p_tar) else $error("flag 28 missing");
  property p_mar; masterAbortReceived ##1 rdS |=> regRdata[29]; endproperty
  a_mar: assert property (p_mar) else $error("flag 29 missing");
  property p_pde; parityErrorDetected ##1 rdS |=> regRdata[31]; endproperty
  a_pde: assert property (p_pde) else $error("flag 31 missing");
  // two sync flops, flag lands on the third low sample
  property p_ser; !secondary_system_error_n [*3] ##1 rdS |=> regRdata[30]; endproperty
  a_ser: assert property (p_ser) else $error("flag 30 missing");
  c_tas: cover property (targetAbortSignaled ##1 rdS);
  c_ser: cover property (!secondary_system_error_n [*3]);
  c_pfn: cover property (regRead && regAddr == 8'h24);
endmodule // bsmw_properties
bind bsmw_regs bsmw_properties u_props (.*);
`default_nettype wire

// ---- sim/bsmw_far_agent.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsmw_far_agent (
  input wire logic clock,
  input wire logic [5:0] kick,
  output logic targetAbortSignaled,
  output logic targetAbortReceived,
  output logic masterAbortReceived,
  output logic parityErrorDetected,
  output logic secondary_parity_error_n,
  output logic secondary_system_error_n
);
  logic [3:0] ev = 4'h0;
  logic [3:0] pe = 4'h0;
  logic [3:0] se = 4'h0;
  // pins stay low four cycles, longer than the sync chain needs
  always @(posedge clock) begin
    ev <= kick[3:0];
    pe <= {pe[2:0], kick[4]};
    se <= {se[2:0], kick[5]};
  end
  assign {parityErrorDetected, masterAbortReceived, targetAbortReceived, targetAbortSignaled} = ev;
  assign secondary_parity_error_n = ~|pe;
  assign secondary_system_error_n = ~|se;
endmodule // bsmw_far_agent
`default_nettype wire

// ---- sim/bridge_secondary_status_memory_windows_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module bridge_secondary_status_memory_windows_tb_top;
  logic clock, rst, regWrite, regRead, txnIs64, memWindowHit, prefetchWindowHit, forwardHit, em, ep;
  logic secondary_parity_error_n, secondary_system_error_n, targetAbortSignaled;
  logic targetAbortReceived, masterAbortReceived, parityErrorDetected;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, base, m;
  logic [63:0] txnAddr, a;
  logic [5:0] kick;
  int num_errors = 0, samples_checked = 0;
  int bitPos[6] = '{27, 28, 29, 31, 24, 30};
  logic [63:0] adr[6] = '{64'h0FFF_FFFF, 64'h1000_0000, 64'h1_123F_FFFF, 64'h1_1240_0000,
    64'h1_0010_0000, 64'h1_002F_FFFF};
  bsmw_regs dut (.*);
  bsmw_far_agent far (.*);
  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    regAddr <= ad;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] ad, input logic [31:0] e);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk("rdata", regRdata, e);
    @(posedge clock);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100000;
    num_errors++;
    complete_run;
  end
  initial begin
    {rst, regWrite, regRead, txnIs64, regAddr, regWdata, txnAddr, kick} = '0;
    rst = 1'b1;
    base = 32'h0220_0000;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(8'h1C, base);
    rd(8'h24, 32'h0001_0001);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, base);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'hFFF0_FFF0);
    // parity pin with response disabled must not set anything
    for (int i = 0; i < 7; i++) begin
      kick <= (i == 0) ? 6'h10 : 6'h01 << (i - 1);
      @(posedge clock);
      kick <= 6'h00;
      @(posedge clock);
      if (i == 0 || i > 4) repeat (2) @(posedge clock);
      m = (i == 0) ? 32'h0 : 32'h1 << bitPos[i - 1];
      rd(8'h1C, base | m);
      wr(8'h1C, ~m & 32'h00FF_FFFF);
      rd(8'h1C, base | m);
      wr(8'h1C, m);
      rd(8'h1C, base);
      if (i == 0) wr(8'h04, 32'h40);
      if (i == 0) rd(8'h04, 32'h40);
    end
    wr(8'h20, 32'h1230_1000);
    wr(8'h24, 32'h0020_0010);
    wr(8'h28, 32'h1);
    wr(8'h2C, 32'h1);
    rd(8'h2C, 32'h1);
    for (int w = 0; w < 2; w++) begin
      for (int j = 0; j < 6; j++) begin
        a = w ? adr[j] : {32'h0, adr[j][31:0]};
        em = a >= 64'h1000_0000 && a <= 64'h123F_FFFF;
        ep = a >= 64'h1_0010_0000 && a <= 64'h1_002F_FFFF;
        txnIs64 <= w[0];
        txnAddr <= adr[j];
        #1 chk("hits", {forwardHit, prefetchWindowHit, memWindowHit}, {em | ep, ep, em});
        @(posedge clock);
      end
    end
    complete_run;
  end
endmodule // bridge_secondary_status_memory_windows_tb_top
`default_nettype wire
